// *** logic/serial_ctrl_pkg.sv ***
package serial_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CHAN1_CTRL  = 8'h1c;
    localparam logic [7:0] OFS_CHAN2_CTRL  = 8'h2c;
    localparam logic [7:0] OFS_CHAN3_CTRL  = 8'h3c;
    localparam logic [7:0] OFS_CHAN4_CTRL  = 8'h4c;
    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h60;
    localparam logic [7:0] OFS_IRQ_LATCHED = 8'h64;
    localparam logic [7:0] OFS_IRQ_TRIG    = 8'h68;
    localparam logic [7:0] OFS_IRQ_POL     = 8'h6c;
    localparam logic [7:0] OFS_CHAN1_PIN   = 8'h80;
    localparam logic [7:0] OFS_CHAN2_PIN   = 8'h84;
    localparam logic [7:0] OFS_CHAN3_PIN   = 8'h88;
    localparam logic [7:0] OFS_CHAN4_PIN   = 8'h8c;

    // control/status field positions
    localparam int CS_RX_GAP_EN    = 30;
    localparam int CS_RX_CNT_RST   = 29;
    localparam int CS_TX_LSB       = 28;
    localparam int CS_RX_LSB       = 27;
    localparam int CS_TX_STOP_EMPT = 26;
    localparam int CS_TX_EN        = 25;
    localparam int CS_RX_EN        = 24;
    localparam int CS_RX_STOP_FULL = 19;
    localparam int CS_RX_UNDERFLOW = 18;
    localparam int CS_TX_OVERFLOW  = 17;
    localparam int CS_RX_OVERFLOW  = 16;
    localparam int CS_FLAGS_LO     = 8;
    localparam int CS_RX_FIFO_RST  = 1;
    localparam int CS_TX_FIFO_RST  = 0;

    // pin configuration field positions
    localparam int PC_XCVR_EN      = 31;
    localparam int PC_EXT_LB       = 29;
    localparam int PC_DCE          = 28;
    localparam int PC_PROTO_LO     = 24;
    localparam int PC_INTERNAL_LOOPBACK_SEL       = 23;
    localparam int PC_TXC_IDLE     = 20;
    localparam int PC_TXD_IDLE     = 19;

    // writable masks and reset values
    localparam logic [31:0] CS_CTRL_MASK   = 32'h7ff8_0000;
    localparam logic [31:0] PC_RW_MASK     = 32'hbfff_ffff;
    localparam logic [31:0] PC_RESET       = 32'h0000_0020;
    localparam logic [31:0] IRQ_EN_RESET   = 32'h0000_0000;
    localparam logic [31:0] IRQ_POL_RESET  = 32'hffff_ffff;
    localparam logic [31:0] IRQ_TRIG_VALUE = 32'hffff_ffff;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

    // protocol encodings
    localparam logic [3:0] PROTO_RS422 = 4'h0;
    localparam logic [3:0] PROTO_RS232 = 4'h2;

    localparam int NUM_CHAN = 4;

    // fifo flags per channel, active high
    typedef struct packed {
        logic rx_full;
        logic rx_afull;
        logic rx_aempty;
        logic rx_empty;
        logic tx_full;
        logic tx_afull;
        logic tx_aempty;
        logic tx_empty;
    } fifo_flags_t;

    // fifo error events per channel, one-cycle pulses
    typedef struct packed {
        logic rx_underflow;
        logic tx_overflow;
        logic rx_overflow;
    } fifo_events_t;

    // per-channel controls toward the serial engine
    typedef struct packed {
        logic rx_capture;
        logic rx_cnt_clear;
        logic tx_lsb_first;
        logic rx_lsb_first;
        logic tx_enable;
        logic rx_fifo_reset;
        logic tx_fifo_reset;
    } chan_ctrl_t;

    // per-channel cable transceiver controls
    typedef struct packed {
        logic       xcvr_oe;
        logic       dce_mode;
        logic       rs232_mode;
        logic       proto_bad;
        logic       ext_loop;
        logic       int_loop;
    } xcvr_ctrl_t;

    // decode byte offset of a channel control register: index 0..3
    function automatic logic [1:0] chan_index(input logic [7:0] ofs);
        chan_index = 2'(((ofs >> 4) - 8'h1) & 8'h3);
    endfunction

endpackage

// *** logic/serial_channel_ctrl_irq.sv ***
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - with gap enable, capture starts after enable and envelope negated.
// - writing one to bit count reset clears receive bit counter.
// - transmit and receive bit order: zero msb first, one lsb first.
// - stop-on-empty clears transmit enable when transmit fifo empties.
// - receive overflow latches; writing one clears it.
// - transmit overflow and receive underflow also latch in status.
// - the eight fifo flag bits read zero when the condition holds.
// - fifo reset bits pulse one cycle then read zero.
// - thirty-two interrupt sources, source n on bit n.
// - sources 0-15 envelope/tx aempty/rx afull/spare; 16-31 empties, fulls.
// - rising edge by default, falling edge when selected.
// - all sources merge onto one interrupt request, copied to all four o_irq bits.
// - enable bit one enables a source; disabled never interrupts.
// - status latches until written one or source disabled.
// - trigger type register is read only and reads all edge.
// - polarity register picks rising or falling edge per source.
// - transceiver enable on turns drivers on; off tristates them all.
// - with drivers on, external loopback ties transmit to receive at the cable.
// - role bit one selects dce, zero dte.
// - protocol zero is rs422/485, bit 25 alone is rs232.
// - internal loopback routes transmit signals back to the receiver.
// - while idle, clock idles at its level; data low when bit zero.
// - transmit data idles high when its idle bit is one.
// - receive stop-on-full disables the receiver when fifo fills.
module serial_channel_ctrl_irq
    import serial_ctrl_pkg::*;
(
    input  wire logic                         i_clk,
    input  wire logic                         i_reset_n,
    input  wire logic                         i_wb_cyc,
    input  wire logic                         i_wb_stb,
    input  wire logic                         i_wb_we,
    input  wire logic [7:0]                   i_wb_adr,
    input  wire logic [3:0]                   i_wb_sel,
    input  wire logic [31:0]                  i_wb_dat,
    output logic      [31:0]                  o_wb_dat,
    output logic                              o_wb_ack,
    input  wire fifo_flags_t [NUM_CHAN-1:0]   i_fifo_flags,
    input  wire fifo_events_t [NUM_CHAN-1:0]  i_fifo_events,
    input  wire logic [NUM_CHAN-1:0]          i_receive_envelope,
    input  wire logic [NUM_CHAN-1:0]          i_receive_spare_input,
    input  wire logic [NUM_CHAN-1:0]          i_tx_clock_raw,
    input  wire logic [NUM_CHAN-1:0]          i_tx_data_raw,
    input  wire logic [NUM_CHAN-1:0]          i_transmit_envelope,
    output chan_ctrl_t [NUM_CHAN-1:0]         o_chan_ctrl,
    output xcvr_ctrl_t [NUM_CHAN-1:0]         o_xcvr_ctrl,
    output logic [NUM_CHAN-1:0]               o_transmit_clock_line,
    output logic [NUM_CHAN-1:0]               o_tx_data_line,
    output logic [NUM_CHAN-1:0]               o_irq
);

    // reset release through two flops
    logic       rst_meta_q;
    logic       rst_n_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // cable inputs cross in through two flops; first stage read by second only
    logic [NUM_CHAN-1:0] env_meta_q, env_q, spare_meta_q, spare_q;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            env_meta_q   <= '0;
            env_q        <= '0;
            spare_meta_q <= '0;
            spare_q      <= '0;
        end else begin
            env_meta_q   <= i_receive_envelope;
            env_q        <= env_meta_q;
            spare_meta_q <= i_receive_spare_input;
            spare_q      <= spare_meta_q;
        end
    end

    // bus decode: one word per register, ack one cycle after request
    logic        req;
    logic        wr;
    logic        ack_q;
    logic [31:0] rdata_q;

    assign req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr  = req && i_wb_we;

    // byte enables expanded to a bit mask
    logic [31:0] be_mask;
    assign be_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                      {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    logic [NUM_CHAN-1:0] wr_cs, wr_pin;
    logic                wr_en, wr_clr, wr_pol;

    always_comb begin
        wr_cs  = '0;
        wr_pin = '0;
        wr_en  = 1'b0;
        wr_clr = 1'b0;
        wr_pol = 1'b0;
        if (!wr) begin
            wr_en = 1'b0;
        end else if (i_wb_adr == OFS_CHAN1_CTRL || i_wb_adr == OFS_CHAN2_CTRL
                     || i_wb_adr == OFS_CHAN3_CTRL
                     || i_wb_adr == OFS_CHAN4_CTRL) begin
            wr_cs[chan_index(i_wb_adr)] = 1'b1;
        end else if (i_wb_adr == OFS_IRQ_ENABLE) begin
            wr_en = 1'b1;
        end else if (i_wb_adr == OFS_IRQ_LATCHED) begin
            wr_clr = 1'b1;
        end else if (i_wb_adr == OFS_IRQ_POL) begin
            wr_pol = 1'b1;
        end else if (i_wb_adr[7:4] == OFS_CHAN1_PIN[7:4]
                     && i_wb_adr[1:0] == 2'h0) begin
            wr_pin[i_wb_adr[3:2]] = 1'b1;
        end
    end

    // per-channel control and pin configuration words
    logic [31:0] cs_q  [NUM_CHAN];
    logic [31:0] pin_q [NUM_CHAN];
    logic [2:0]  lat_q [NUM_CHAN];
    logic [NUM_CHAN-1:0] capture_q, rx_full_d1_q, tx_empty_d1_q;

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic [31:0] wval;
            assign wval = (cs_q[c] & ~be_mask) | (i_wb_dat & be_mask);

            // control bits; pulse bits self-clear after one cycle
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    cs_q[c] <= '0;
                end else begin
                    cs_q[c][CS_RX_CNT_RST] <= 1'b0;
                    cs_q[c][CS_RX_FIFO_RST] <= 1'b0;
                    cs_q[c][CS_TX_FIFO_RST] <= 1'b0;
                    if (wr_cs[c]) begin
                        cs_q[c] <= wval & CS_CTRL_MASK;
                        cs_q[c][CS_RX_FIFO_RST] <= wval[CS_RX_FIFO_RST];
                        cs_q[c][CS_TX_FIFO_RST] <= wval[CS_TX_FIFO_RST];
                        cs_q[c][CS_RX_CNT_RST] <= wval[CS_RX_CNT_RST];
                    end
                    // auto stop on empty, wins over a write
                    if (cs_q[c][CS_TX_STOP_EMPT] && i_fifo_flags[c].tx_empty
                        && !tx_empty_d1_q[c]) begin
                        cs_q[c][CS_TX_EN] <= 1'b0;
                    end
                    if (cs_q[c][CS_RX_STOP_FULL] && i_fifo_flags[c].rx_full
                        && !rx_full_d1_q[c]) begin
                        cs_q[c][CS_RX_EN] <= 1'b0;
                    end
                end
            end

            // edge history for stop conditions
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    rx_full_d1_q[c]  <= 1'b0;
                    tx_empty_d1_q[c] <= 1'b0;
                end else begin
                    rx_full_d1_q[c]  <= i_fifo_flags[c].rx_full;
                    tx_empty_d1_q[c] <= i_fifo_flags[c].tx_empty;
                end
            end

            // latched error bits; set wins over clear
            // transmit overflow and receive underflow alike
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    lat_q[c] <= '0;
                end else begin
                    lat_q[c] <= (lat_q[c] & ~({3{wr_cs[c]}}
                                & wval[CS_RX_UNDERFLOW:CS_RX_OVERFLOW]))
                              | i_fifo_events[c];
                end
            end

            // gap mode holds capture off until envelope negated
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q)
                    capture_q[c] <= 1'b0;
                else if (!cs_q[c][CS_RX_EN])
                    capture_q[c] <= 1'b0;
                else if (!cs_q[c][CS_RX_GAP_EN] || !env_q[c])
                    capture_q[c] <= 1'b1;
            end

            // pin configuration word
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    pin_q[c] <= PC_RESET;
                end else if (wr_pin[c]) begin
                    pin_q[c] <= ((pin_q[c] & ~be_mask) | (i_wb_dat & be_mask))
                                & PC_RW_MASK;
                end
            end

            // serial engine controls, registered
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    o_chan_ctrl[c] <= '0;
                end else begin
                    o_chan_ctrl[c].rx_capture    <= capture_q[c];
                    o_chan_ctrl[c].rx_cnt_clear  <= cs_q[c][CS_RX_CNT_RST];
                    o_chan_ctrl[c].tx_lsb_first  <= cs_q[c][CS_TX_LSB];
                    o_chan_ctrl[c].rx_lsb_first  <= cs_q[c][CS_RX_LSB];
                    o_chan_ctrl[c].tx_enable     <= cs_q[c][CS_TX_EN];
                    o_chan_ctrl[c].rx_fifo_reset <= cs_q[c][CS_RX_FIFO_RST];
                    o_chan_ctrl[c].tx_fifo_reset <= cs_q[c][CS_TX_FIFO_RST];
                end
            end

            // transceiver controls; reserved protocol codes flagged
            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    o_xcvr_ctrl[c] <= '0;
                end else begin
                    o_xcvr_ctrl[c].xcvr_oe  <= pin_q[c][PC_XCVR_EN];
                    o_xcvr_ctrl[c].dce_mode <= pin_q[c][PC_DCE];
                    o_xcvr_ctrl[c].rs232_mode <=
                        pin_q[c][PC_PROTO_LO+3:PC_PROTO_LO] == PROTO_RS232;
                    o_xcvr_ctrl[c].proto_bad <=
                        pin_q[c][PC_PROTO_LO+3:PC_PROTO_LO] != PROTO_RS232 &&
                        pin_q[c][PC_PROTO_LO+3:PC_PROTO_LO] != PROTO_RS422;
                    // cable loopback only with drivers on
                    o_xcvr_ctrl[c].ext_loop <= pin_q[c][PC_EXT_LB]
                                               && pin_q[c][PC_XCVR_EN];
                    o_xcvr_ctrl[c].int_loop <= pin_q[c][PC_INTERNAL_LOOPBACK_SEL];
                end
            end

            always_ff @(posedge i_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    o_transmit_clock_line[c] <= 1'b0;
                    o_tx_data_line[c]        <= 1'b0;
                end else if (!i_transmit_envelope[c]) begin
                    o_transmit_clock_line[c] <= pin_q[c][PC_TXC_IDLE];
                    o_tx_data_line[c]        <= pin_q[c][PC_TXD_IDLE];
                end else begin
                    o_transmit_clock_line[c] <= i_tx_clock_raw[c];
                    o_tx_data_line[c]        <= i_tx_data_raw[c];
                end
            end
        end
    endgenerate

    logic [31:0] src, src_d1_q, irq_en_q, irq_pol_q, irq_lat_q;

    always_comb begin
        for (int k = 0; k < NUM_CHAN; k++) begin
            src[4*k]      = env_q[k];
            src[4*k+1]    = i_fifo_flags[k].tx_aempty;
            src[4*k+2]    = i_fifo_flags[k].rx_afull;
            src[4*k+3]    = spare_q[k];
            src[16+4*k]   = i_fifo_flags[k].tx_empty;
            src[16+4*k+1] = i_fifo_flags[k].tx_full;
            src[16+4*k+2] = i_fifo_flags[k].rx_empty;
            src[16+4*k+3] = i_fifo_flags[k].rx_full;
        end
    end

    // enable and polarity registers
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_en_q  <= IRQ_EN_RESET;
            irq_pol_q <= IRQ_POL_RESET;
        end else begin
            if (wr_en)
                irq_en_q <= (irq_en_q & ~be_mask) | (i_wb_dat & be_mask);
            if (wr_pol)
                irq_pol_q <= (irq_pol_q & ~be_mask) | (i_wb_dat & be_mask);
        end
    end

    // edge detect, pol one is rising
    // latched until w1c or disabled; new edge wins over clear
    logic [31:0] edge_hit;
    assign edge_hit = (irq_pol_q & src & ~src_d1_q)
                    | (~irq_pol_q & ~src & src_d1_q);

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_d1_q  <= '0;
            irq_lat_q <= '0;
        end else begin
            src_d1_q  <= src;
            irq_lat_q <= ((irq_lat_q & ~({32{wr_clr}} & i_wb_dat & be_mask))
                          | edge_hit) & irq_en_q;
        end
    end

    // high while any latched enabled bit
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q)
            o_irq <= '0;
        else
            o_irq <= {NUM_CHAN{|(irq_lat_q & irq_en_q)}};
    end

    // read mux
    function automatic logic [31:0] cs_read(input int k);
        logic [31:0] v;
        v = cs_q[k];
        v[CS_RX_UNDERFLOW:CS_RX_OVERFLOW] = lat_q[k];
        v[CS_FLAGS_LO+7:CS_FLAGS_LO] = ~i_fifo_flags[k];
        return v;
    endfunction

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= req;
            if (!req)
                rdata_q <= rdata_q;
            else if (i_wb_adr == OFS_CHAN1_CTRL || i_wb_adr == OFS_CHAN2_CTRL
                     || i_wb_adr == OFS_CHAN3_CTRL
                     || i_wb_adr == OFS_CHAN4_CTRL)
                rdata_q <= cs_read(int'(chan_index(i_wb_adr)));
            else if (i_wb_adr == OFS_IRQ_ENABLE)
                rdata_q <= irq_en_q;
            else if (i_wb_adr == OFS_IRQ_LATCHED)
                rdata_q <= irq_lat_q;
            else if (i_wb_adr == OFS_IRQ_TRIG)
                rdata_q <= IRQ_TRIG_VALUE;
            else if (i_wb_adr == OFS_IRQ_POL)
                rdata_q <= irq_pol_q;
            else if (i_wb_adr[7:4] == OFS_CHAN1_PIN[7:4]
                     && i_wb_adr[1:0] == 2'h0)
                rdata_q <= pin_q[i_wb_adr[3:2]];
            else
                rdata_q <= UNMAPPED_VALUE;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdata_q;

endmodule

// *** test/serial_ctrl_monitor.sv ***
`timescale 1ns/1ps
module serial_ctrl_monitor
    import serial_ctrl_pkg::*;
(
    input wire logic                      i_clk,
    input wire logic                      i_reset_n,
    input wire logic                      i_wb_cyc,
    input wire logic                      i_wb_stb,
    input wire logic [31:0]               o_wb_dat,
    input wire logic                      o_wb_ack,
    input wire chan_ctrl_t [NUM_CHAN-1:0] o_chan_ctrl,
    input wire xcvr_ctrl_t [NUM_CHAN-1:0] o_xcvr_ctrl,
    input wire logic [NUM_CHAN-1:0]       o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // a request the slave has not yet answered
    sequence s_taken;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_rst_pulse;
        $rose(o_chan_ctrl[0].tx_fifo_reset) ##1 $fell(o_chan_ctrl[0].tx_fifo_reset);
    endsequence
    // bus answer timing
    a_ack_answer: assert property (s_taken |=> o_wb_ack)
        else $error("request not answered next cycle");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_dat_stable: assert property (!o_wb_ack && !$past(i_wb_cyc && i_wb_stb)
        |-> $stable(o_wb_dat)) else $error("read data moved while idle");
    a_irq_shared: assert property (o_irq == {4{o_irq[0]}})
        else $error("interrupt copies differ");
    a_rxrst_pulse: assert property (o_chan_ctrl[0].rx_fifo_reset |=>
        !o_chan_ctrl[0].rx_fifo_reset) else $error("rx fifo reset held");
    a_txrst_pulse: assert property ($rose(o_chan_ctrl[0].tx_fifo_reset)
        |-> s_rst_pulse) else $error("tx fifo reset held");
    a_cnt_pulse: assert property (o_chan_ctrl[0].rx_cnt_clear[*2]
        |-> 1'b0) else $error("bit count clear held");
    a_loop_needs_xcvr: assert property (o_xcvr_ctrl[0].ext_loop
        |-> o_xcvr_ctrl[0].xcvr_oe) else $error("loopback without drivers");
    a_proto_excl: assert property (!(o_xcvr_ctrl[0].rs232_mode
        && o_xcvr_ctrl[0].proto_bad)) else $error("protocol both modes");
endmodule
bind serial_channel_ctrl_irq serial_ctrl_monitor mon (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_chan_ctrl(o_chan_ctrl),
    .o_xcvr_ctrl(o_xcvr_ctrl), .o_irq(o_irq));

// *** test/far_end_model.sv ***
`timescale 1ns/1ps
module far_end_model (
    input  wire logic       i_frame_go,
    output logic [3:0]      o_envelope,
    output logic [3:0]      o_spare
);
    logic link_clk;
    initial begin
        o_envelope = 4'h0;
        o_spare = 4'h0;
        link_clk = 1'b0;
    end
    // one frame per request; link clock stands still between frames
    always @(posedge i_frame_go) begin
        #137;
        o_envelope = 4'hf;
        repeat (8) begin
            #200;
            link_clk = ~link_clk;
            if (link_clk) o_spare = ~o_spare; // data moves on rising edge
        end
        o_envelope = 4'h0;
    end
endmodule

// *** test/serial_channel_ctrl_irq_bench.sv ***
`timescale 1ns/1ps
module serial_channel_ctrl_irq_bench import serial_ctrl_pkg::*;;
    logic i_clk = 0, i_reset_n = 0, cyc = 0, stb = 0, we = 0, go = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, o_dat;
    logic [3:0]  sel = 4'hf, txenv = 4'h0, txraw = 4'h0, env, spare;
    logic [3:0]  tcl, tdl, irq;
    logic        ack;
    fifo_flags_t  [3:0] flags = '0;
    fifo_events_t [3:0] evts = '0;
    chan_ctrl_t   [3:0] cc;
    xcvr_ctrl_t   [3:0] xc;
    int num_errors = 0, tests_run = 0;

    always #25 i_clk = ~i_clk;

    serial_channel_ctrl_irq DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack),
        .i_fifo_flags(flags), .i_fifo_events(evts),
        .i_receive_envelope(env), .i_receive_spare_input(spare),
        .i_tx_clock_raw(txraw), .i_tx_data_raw(txraw),
        .i_transmit_envelope(txenv), .o_chan_ctrl(cc), .o_xcvr_ctrl(xc),
        .o_transmit_clock_line(tcl), .o_tx_data_line(tdl), .o_irq(irq));
    far_end_model far (.i_frame_go(go), .o_envelope(env), .o_spare(spare));

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            num_errors++;
            results();
        end else begin
            rdat = o_dat;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        // reset values, read-only info, unmapped hole
        for (int c = 0; c < 4; c++) rd(OFS_CHAN1_PIN + 8'(4 * c), PC_RESET);
        rd(OFS_IRQ_ENABLE, IRQ_EN_RESET);
        rd(OFS_IRQ_POL, IRQ_POL_RESET);
        wr(OFS_IRQ_TRIG, 32'h0);
        rd(OFS_IRQ_TRIG, 32'hffff_ffff);
        rd(8'h50, UNMAPPED_VALUE);
        // drivers on, dce, rs232, both loopbacks, clock idles high
        wr(OFS_CHAN1_PIN, 32'hb290_0000);
        rd(OFS_CHAN1_PIN, 32'hb290_0000);
        chk(32'({xc[0].xcvr_oe, xc[0].dce_mode, xc[0].rs232_mode,
            xc[0].proto_bad, xc[0].ext_loop, xc[0].int_loop}),
            32'h3b);
        chk(32'({tcl[0], tdl[0]}), 32'h2);
        // drivers off: loopback dropped, reserved protocol, data idles high
        wr(OFS_CHAN1_PIN, 32'h2108_0000);
        step(2);
        chk(32'({xc[0].xcvr_oe, xc[0].proto_bad, xc[0].ext_loop, tcl[0],
            tdl[0]}), 32'h09);
        // envelope asserted: lines follow the engine, not the idle levels
        txenv <= 4'h1;
        txraw <= 4'h1;
        step(2);
        chk(32'({tcl[0], tdl[0]}), 32'h3);
        txenv <= 4'h0;
        // transceivers on before any transmit or receive enable
        wr(OFS_CHAN1_PIN, 32'h8000_0000);
        // bit order per direction, plain receive enable
        wr(OFS_CHAN1_CTRL, 32'h1900_0000);
        step(2);
        chk(32'({cc[0].tx_lsb_first, cc[0].rx_lsb_first, cc[0].rx_capture}),
            32'h7);
        wr(OFS_CHAN1_CTRL, 32'h0900_0000);
        step(2);
        chk(32'({cc[0].tx_lsb_first, cc[0].rx_lsb_first}), 32'h1);
        // pulses self-clear; flags read active low
        wr(OFS_CHAN1_CTRL, 32'h2000_0000);
        step(0);
        chk(32'(cc[0].rx_cnt_clear), 32'h1);
        wr(OFS_CHAN1_CTRL, 32'h0000_0003);
        step(0);
        chk(32'({cc[0].rx_fifo_reset, cc[0].tx_fifo_reset}), 32'h3);
        rd(OFS_CHAN1_CTRL, 32'h0000_ff00);
        flags[0] <= 8'h81;
        step(2);
        rd(OFS_CHAN1_CTRL, 32'h0000_7e00);
        // error events latch; overflow cleared by writing one
        evts[0] <= 3'h7;
        step(1);
        evts[0] <= 3'h0;
        step(2);
        rd(OFS_CHAN1_CTRL, 32'h0007_7e00);
        wr(OFS_CHAN1_CTRL, 32'h0001_0000);
        bus(1'b0, OFS_CHAN1_CTRL, 32'h0);
        chk(32'(rdat[16]), 32'h0);
        // stop on empty and stop on full when flags rise
        flags[0] <= 8'h00;
        wr(OFS_CHAN1_CTRL, 32'h0708_0000);
        step(2);
        chk(32'({cc[0].tx_enable, cc[0].rx_capture}), 32'h3);
        flags[0] <= 8'h81;
        step(3);
        chk(32'({cc[0].tx_enable, cc[0].rx_capture}), 32'h0);
        // edge interrupts on ch1 tx empty, source 16
        wr(OFS_IRQ_ENABLE, 32'h0001_0001);
        flags[0] <= 8'h80;
        step(3);
        rd(OFS_IRQ_LATCHED, 32'h0);
        flags[0] <= 8'h81;
        step(3);
        chk(32'(irq), 32'hf);
        rd(OFS_IRQ_LATCHED, 32'h0001_0000);
        wr(OFS_IRQ_LATCHED, 32'h0001_0000);
        step(3);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_POL, 32'hfffe_ffff);
        flags[0] <= 8'h80;
        step(3);
        rd(OFS_IRQ_LATCHED, 32'h0001_0000);
        wr(OFS_IRQ_ENABLE, 32'h0000_0001);
        rd(OFS_IRQ_LATCHED, 32'h0);
        flags[0] <= 8'h81;
        step(3);
        rd(OFS_IRQ_LATCHED, 32'h0);
        // gap mode waits for the far end's frame to end
        go <= 1'b1;
        step(10);
        wr(OFS_CHAN1_CTRL, 32'h4100_0000);
        step(2);
        chk(32'(cc[0].rx_capture), 32'h0);
        step(40);
        chk(32'(cc[0].rx_capture), 32'h1);
        rd(OFS_IRQ_LATCHED, 32'h0000_0001);
        go <= 1'b0;
        results();
    end
endmodule
